// ===== core/hpr_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes DEPTH is a power of two; data out is read from the array flops
`timescale 1ns/1ns
module hpr_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) &&
                       (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // storage needs no reset; out_valid guards every read
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule

// ===== core/hpr_router.sv
// hub forwarding logic: downstream routing, upstream merge, link power
// assumes link layers below give word streams and link-state levels
`timescale 1ns/1ns

// What this block does
// - Request upstream low power once all downstream links are asleep.
// - Per-port idle timer, host-programmed, asks its link to sleep on expiry.
// - Routed downstream packets go only to the addressed port.
// - Packets from all downstream ports merge onto the upstream port.
// - Timestamp packets copy to every awake, unsuspended port, never to sleeping ones.
// - Packet to a sleeping port wakes it and notifies host and device.
// - Port suspend only flags the port; timestamp packets then skip it.
// - Ports suspend only on a command, never on their own.
// - Remote wake is reported only when host enabled it for that port.
// - Remote wake reaches the host whatever link states lie on the path.
// - Attach, removal and remote wake are detected and reported.
// - Reset and suspend are generated and propagated in hardware; resume needs a per-port command or reset.
module hpr_router
  import hpr_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic                      dn_in_valid,
  output logic                           dn_in_ready,
  input  wire logic [DATA_W-1:0]         dn_in_data,
  input  wire logic                      dn_in_last,
  input  wire logic [ROUTE_W-1:0]        dn_in_route,
  input  wire logic                      dn_in_tsp,
  output logic      [N_PORTS-1:0]        port_tx_valid,
  input  wire logic [N_PORTS-1:0]        port_tx_ready,
  output logic      [DATA_W-1:0]         port_tx_data,
  output logic                           port_tx_last,
  input  wire logic [N_PORTS-1:0]        port_rx_valid,
  output logic      [N_PORTS-1:0]        port_rx_ready,
  input  wire logic [N_PORTS*DATA_W-1:0] port_rx_data,
  input  wire logic [N_PORTS-1:0]        port_rx_last,
  output logic                           up_tx_valid,
  input  wire logic                      up_tx_ready,
  output logic      [DATA_W-1:0]         up_tx_data,
  output logic                           up_tx_last,
  input  wire logic                      up_link_active,
  output logic                           up_lp_req,
  output logic                           up_wake_req,
  input  wire logic [N_PORTS-1:0]        port_link_active,
  output logic      [N_PORTS-1:0]        port_wake_req,
  output logic      [N_PORTS-1:0]        port_lp_req,
  output logic                           wake_notice_host,
  output logic      [N_PORTS-1:0]        wake_notice_port,
  input  wire logic [TIMER_W-1:0]        idle_timeout,
  input  wire logic [N_PORTS-1:0]        port_suspend_cmd,
  input  wire logic [N_PORTS-1:0]        port_resume_cmd,
  output logic      [N_PORTS-1:0]        port_suspended,
  input  wire logic                      hub_suspend,
  input  wire logic                      up_reset,
  input  wire logic [N_PORTS-1:0]        port_reset_cmd,
  output logic      [N_PORTS-1:0]        port_reset,
  input  wire logic [N_PORTS-1:0]        port_connected,
  input  wire logic [N_PORTS-1:0]        rwake_enable,
  input  wire logic [N_PORTS-1:0]        port_remote_wake,
  output logic      [N_PORTS-1:0]        attach_evt,
  output logic      [N_PORTS-1:0]        detach_evt,
  output logic      [N_PORTS-1:0]        rwake_evt
);
  logic                rst_meta;
  logic                rst_n;
  logic [TICK_W-1:0]   tick_cnt;
  logic [TICK_W-1:0]   next_tick_cnt;
  logic                tick;
  hpr_dn_state_t       state;
  hpr_dn_state_t       next_state;
  logic [N_PORTS-1:0]  mask;
  logic [N_PORTS-1:0]  next_mask;
  logic                cur_tsp;
  logic                next_cur_tsp;
  logic                next_wake_notice_host;
  logic [N_PORTS-1:0]  next_wake_notice_port;
  logic                f_valid;
  logic                f_pop;
  logic [DNW_W-1:0]    f_word;
  logic                f_tsp;
  logic [N_PORTS-1:0]  f_onehot;
  logic                up_valid;
  logic                next_up_valid;
  logic [DATA_W-1:0]   next_up_data;
  logic                next_up_last;
  logic                locked;
  logic                next_locked;
  logic [ROUTE_W-1:0]  owner;
  logic [ROUTE_W-1:0]  next_owner;
  logic [ROUTE_W-1:0]  rr;
  logic [ROUTE_W-1:0]  next_rr;
  logic [ROUTE_W-1:0]  sel;
  logic                sel_valid;
  logic                take;
  logic                up_load;
  logic [N_PORTS-1:0]  conn_q;
  logic [N_PORTS-1:0]  rw_q;
  logic                rwake_pend;
  logic                next_rwake_pend;
  logic                next_up_lp_req;
  logic [N_PORTS-1:0]  next_attach;
  logic [N_PORTS-1:0]  next_detach;
  logic [N_PORTS-1:0]  next_rwake;
  logic [N_PORTS-1:0]  next_port_reset;
  logic [N_PORTS-1:0]  next_suspended;

  // reset is released through two flops; only the second is used
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // microsecond enable for the idle timers
  always_comb
  begin
    next_tick_cnt = (tick_cnt == TICK_LAST) ? '0 : tick_cnt + 1'b1;
  end
  assign tick = (tick_cnt == TICK_LAST);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt <= '0;
    else
      tick_cnt <= next_tick_cnt;
  end

  // the fifo decouples the upstream link from slow downstream ports
  hpr_fifo #(.WIDTH(DNW_W), .DEPTH(FIFO_DEPTH)) u_dn_fifo
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (dn_in_valid),
    .in_ready  (dn_in_ready),
    .in_data   ({dn_in_tsp, dn_in_route, dn_in_last, dn_in_data}),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_word)
  );

  assign f_tsp        = f_word[DNW_TSP];
  assign f_onehot     = PORT_ONE << f_word[DNW_ROUTE_LO +: ROUTE_W];
  assign port_tx_data = f_word[DATA_W-1:0];
  assign port_tx_last = f_word[DNW_LAST];
  // a word leaves only when every selected port takes it together
  assign f_pop = (state == HPR_SEND) && f_valid &&
                 (&(~mask | port_tx_ready));
  assign port_tx_valid =
    (state == HPR_SEND && f_valid) ? mask : PORT_NONE;
  assign port_wake_req = (state == HPR_WAKE) ? mask : PORT_NONE;

  always_comb
  begin
    next_state            = state;
    next_mask             = mask;
    next_cur_tsp          = cur_tsp;
    next_wake_notice_host = 1'b0;
    next_wake_notice_port = PORT_NONE;
    case (state)
      HPR_IDLE:
      begin
        if (f_valid)
        begin
          next_cur_tsp = f_tsp;
          if (f_tsp)
          begin
            // empty mask drains the packet: nobody awake to hear it
            next_mask  = port_link_active & ~port_suspended;
            next_state = HPR_SEND;
          end
          else if (|(f_onehot & port_link_active))
          begin
            next_mask  = f_onehot;
            next_state = HPR_SEND;
          end
          else
          begin
            next_mask             = f_onehot;
            next_state            = HPR_WAKE;
            next_wake_notice_host = 1'b1;
            next_wake_notice_port = f_onehot;
          end
        end
      end
      HPR_WAKE:
      begin
        if (|(mask & port_link_active))
          next_state = HPR_SEND;
      end
      HPR_SEND:
      begin
        if (f_pop && port_tx_last)
          next_state = HPR_IDLE;
      end
      default:
        next_state = HPR_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state            <= HPR_IDLE;
      mask             <= PORT_NONE;
      cur_tsp          <= 1'b0;
      wake_notice_host <= 1'b0;
      wake_notice_port <= PORT_NONE;
    end
    else
    begin
      state            <= next_state;
      mask             <= next_mask;
      cur_tsp          <= next_cur_tsp;
      wake_notice_host <= next_wake_notice_host;
      wake_notice_port <= next_wake_notice_port;
    end
  end

  // upstream merge: round robin, held to one port until its last word
  always_comb
  begin
    sel       = '0;
    sel_valid = 1'b0;
    if (locked)
    begin
      sel       = owner;
      sel_valid = port_rx_valid[owner];
    end
    else
    begin
      for (int k = N_PORTS - 1; k >= 0; k--)
      begin
        if (port_rx_valid[rr + ROUTE_W'(k)])
        begin
          sel       = rr + ROUTE_W'(k);
          sel_valid = 1'b1;
        end
      end
    end
  end

  // holding register only drains while the upstream link is up
  assign up_load = !up_valid || (up_tx_ready && up_link_active);
  assign take    = up_load && sel_valid;
  assign port_rx_ready = take ? (PORT_ONE << sel) : PORT_NONE;
  assign up_tx_valid   = up_valid && up_link_active;
  assign up_wake_req   = !up_link_active &&
    (up_valid || (|port_rx_valid) || rwake_pend);

  always_comb
  begin
    next_up_valid = up_valid && !(up_tx_ready && up_link_active);
    next_up_data  = up_tx_data;
    next_up_last  = up_tx_last;
    next_locked   = locked;
    next_owner    = owner;
    next_rr       = rr;
    if (take)
    begin
      next_up_valid = 1'b1;
      next_up_data  = port_rx_data[int'(sel)*DATA_W +: DATA_W];
      next_up_last  = port_rx_last[sel];
      next_locked   = !port_rx_last[sel];
      next_owner    = sel;
      if (port_rx_last[sel])
        next_rr = sel + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      up_valid   <= 1'b0;
      up_tx_data <= '0;
      up_tx_last <= 1'b0;
      locked     <= 1'b0;
      owner      <= '0;
      rr         <= '0;
    end
    else
    begin
      up_valid   <= next_up_valid;
      up_tx_data <= next_up_data;
      up_tx_last <= next_up_last;
      locked     <= next_locked;
      owner      <= next_owner;
      rr         <= next_rr;
    end
  end

  // port events, suspend, reset and upstream low power
  always_comb
  begin
    next_attach = port_connected & ~conn_q;
    next_detach = ~port_connected & conn_q;
    next_rwake  = port_remote_wake & ~rw_q & rwake_enable;
    // a new wake wins over the clear in the same cycle
    next_rwake_pend = (rwake_pend && !up_link_active) ||
                      (|next_rwake);
    next_port_reset = port_reset_cmd | {N_PORTS{up_reset}};
    // sleeping functions alone never suspend a port
    next_suspended = (port_suspended & ~port_resume_cmd &
                      ~next_port_reset) | port_suspend_cmd |
                     {N_PORTS{hub_suspend}};
    next_up_lp_req = (port_link_active == PORT_NONE) && !up_valid &&
                     !(|port_rx_valid) && !f_valid && !rwake_pend;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conn_q         <= PORT_NONE;
      rw_q           <= PORT_NONE;
      attach_evt     <= PORT_NONE;
      detach_evt     <= PORT_NONE;
      rwake_evt      <= PORT_NONE;
      rwake_pend     <= 1'b0;
      port_reset     <= PORT_NONE;
      port_suspended <= PORT_NONE;
      up_lp_req      <= 1'b0;
    end
    else
    begin
      conn_q         <= port_connected;
      rw_q           <= port_remote_wake;
      attach_evt     <= next_attach;
      detach_evt     <= next_detach;
      rwake_evt      <= next_rwake;
      rwake_pend     <= next_rwake_pend;
      port_reset     <= next_port_reset;
      port_suspended <= next_suspended;
      up_lp_req      <= next_up_lp_req;
    end
  end

  // per-port idle timers; a zero timeout disables them
  for (genvar i = 0; i < N_PORTS; i++)
  begin : g_idle
    logic [TIMER_W-1:0] cnt;
    logic [TIMER_W-1:0] next_cnt;
    logic               fired;
    logic               next_fired;
    logic               next_lp;

    always_comb
    begin
      next_cnt   = cnt;
      next_fired = fired;
      next_lp    = 1'b0;
      if (!port_link_active[i] || port_tx_valid[i] || port_rx_valid[i])
      begin
        next_cnt   = '0;
        next_fired = 1'b0;
      end
      else if (idle_timeout != TIMER_OFF)
      begin
        if (cnt >= idle_timeout)
        begin
          next_lp    = !fired;
          next_fired = 1'b1;
        end
        else if (tick)
          next_cnt = cnt + 1'b1;
      end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        cnt            <= '0;
        fired          <= 1'b0;
        port_lp_req[i] <= 1'b0;
      end
      else
      begin
        cnt            <= next_cnt;
        fired          <= next_fired;
        port_lp_req[i] <= next_lp;
      end
    end

    AST_IDLE_EXPIRY:
      assert property (@(posedge clk) disable iff (!rst_n)
        port_lp_req[i] |-> $past(port_link_active[i]) &&
          $past(idle_timeout) != TIMER_OFF && $past(cnt) >= $past(idle_timeout))
      else $error("idle request without expiry");
    AST_SUSPEND_CMD:
      assert property (@(posedge clk) disable iff (!rst_n)
        $rose(port_suspended[i]) |->
          $past(port_suspend_cmd[i]) || $past(hub_suspend))
      else $error("port suspended without command");
    AST_ATTACH:
      assert property (@(posedge clk) disable iff (!rst_n)
        attach_evt[i] |-> $past(port_connected[i]) &&
          !$past(port_connected[i], 2))
      else $error("attach event without rising connect");
    AST_RWAKE_EN:
      assert property (@(posedge clk) disable iff (!rst_n)
        rwake_evt[i] |-> $past(rwake_enable[i]))
      else $error("remote wake reported while disabled");
  end

  AST_UP_LP:
    assert property (@(posedge clk) disable iff (!rst_n)
      up_lp_req |-> $past(port_link_active) == PORT_NONE)
    else $error("upstream sleep while a port is awake");
  AST_ROUTED_ONE:
    assert property (@(posedge clk) disable iff (!rst_n)
      (port_tx_valid != PORT_NONE && !cur_tsp) |-> $onehot(port_tx_valid))
    else $error("routed packet sent to several ports");
  AST_MERGE:
    assert property (@(posedge clk) disable iff (!rst_n)
      (port_rx_ready != PORT_NONE) |=> up_valid)
    else $error("merged word not held for upstream");
  AST_TSP_AWAKE:
    assert property (@(posedge clk) disable iff (!rst_n)
      (state == HPR_IDLE && f_valid && f_tsp) |=>
        mask == $past(port_link_active & ~port_suspended))
    else $error("timestamp mask includes a sleeping port");
  AST_WAKE_NOTICE:
    assert property (@(posedge clk) disable iff (!rst_n)
      (state == HPR_IDLE ##1 state == HPR_WAKE) |->
        wake_notice_host && wake_notice_port == mask &&
        port_wake_req == mask)
    else $error("wake of sleeping port not notified");
  AST_UP_HOLD:
    assert property (@(posedge clk) disable iff (!rst_n)
      (up_valid && !up_link_active) |-> !up_tx_valid && up_wake_req)
    else $error("upstream send while link asleep");
  AST_RESET_PROP:
    assert property (@(posedge clk) disable iff (!rst_n)
      up_reset |=> port_reset == {N_PORTS{1'b1}})
    else $error("upstream reset not propagated");
endmodule

// ===== shared/hpr_pkg.sv
// constants and types shared by the hub packet router and its fifo
// assumes one 10 MHz clock and four downstream ports
package hpr_pkg;
  localparam int N_PORTS       = 4;
  localparam int DATA_W        = 32;
  localparam int ROUTE_W       = 2;
  localparam int FIFO_DEPTH    = 4;
  localparam int CLK_PERIOD_NS = 100;
  // idle timer unit is one microsecond
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYC      =
    (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W        = 4;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  localparam int TIMER_W       = 16;
  localparam logic [TIMER_W-1:0] TIMER_OFF = 16'h0000;
  // fifo word layout: {tsp, route, last, data}
  localparam int DNW_LAST      = DATA_W;
  localparam int DNW_ROUTE_LO  = DATA_W + 1;
  localparam int DNW_TSP       = DATA_W + ROUTE_W + 1;
  localparam int DNW_W         = DATA_W + ROUTE_W + 2;
  localparam logic [N_PORTS-1:0] PORT_ONE  = 4'h1;
  localparam logic [N_PORTS-1:0] PORT_NONE = 4'h0;

  typedef enum logic [2:0]
  {
    HPR_IDLE = 3'b001,
    HPR_WAKE = 3'b010,
    HPR_SEND = 3'b100
  } hpr_dn_state_t;
endpackage

// ===== verification/hpr_port_model.sv
// link partners on the downstream ports: link state and tx acceptance
// assumes wake_req is a level and lp_req a one-cycle pulse from the router
`timescale 1ns/1ns
module hpr_port_model
  import hpr_pkg::*;
(
  input  wire logic               clk,
  input  wire logic [N_PORTS-1:0] wake_req,
  input  wire logic [N_PORTS-1:0] lp_req,
  input  wire logic [N_PORTS-1:0] sleep,
  input  wire logic [N_PORTS-1:0] dev_wake,
  input  wire logic               stall,
  output logic      [N_PORTS-1:0] link_active,
  output logic      [N_PORTS-1:0] tx_ready
);
  logic [1:0] exit_cnt [N_PORTS];

  initial
  begin
    link_active = '1;
    foreach (exit_cnt[i]) exit_cnt[i] = 2'h3;
  end

  // a sleeping link never accepts words
  assign tx_ready = stall ? PORT_NONE : link_active;

  always @(posedge clk)
    for (int i = 0; i < N_PORTS; i++)
      if (sleep[i] || lp_req[i])
      begin
        link_active[i] <= 1'b0;
        exit_cnt[i]    <= 2'h3;
      end
      else if (dev_wake[i])
        link_active[i] <= 1'b1;
      else if (wake_req[i] && !link_active[i])
      begin
        // slow exit so the router must really wait
        if (exit_cnt[i] == 2'h0)
          link_active[i] <= 1'b1;
        else
          exit_cnt[i] <= exit_cnt[i] - 2'h1;
      end
endmodule

// ===== verification/tb.sv
// self-checking bench for the hub packet router
// assumes the link partner model stands on the downstream ports
`timescale 1ns/1ns
module tb;
  import hpr_pkg::*;
  logic                  clk = 1'b0, reset_n = 1'b0, stall = 1'b0;
  logic                  dn_in_valid = 1'b0, dn_in_last = 1'b1;
  logic                  dn_in_tsp = 1'b0, dn_in_ready, port_tx_last;
  logic                  up_tx_ready = 1'b1, up_link_active = 1'b1;
  logic                  hub_suspend = 1'b0, up_reset = 1'b0;
  logic                  up_tx_valid, up_tx_last, up_lp_req;
  logic                  up_wake_req, wake_notice_host;
  logic [DATA_W-1:0]     dn_in_data = '0, port_tx_data, up_tx_data;
  logic [ROUTE_W-1:0]    dn_in_route = '0;
  logic [TIMER_W-1:0]    idle_timeout = TIMER_OFF;
  logic [N_PORTS*DATA_W-1:0] port_rx_data = '0;
  logic [N_PORTS-1:0]    port_rx_valid = '0, port_rx_last = '1;
  logic [N_PORTS-1:0]    port_suspend_cmd = '0, port_resume_cmd = '0;
  logic [N_PORTS-1:0]    port_reset_cmd = '0, port_connected = '0;
  logic [N_PORTS-1:0]    rwake_enable = '0, port_remote_wake = '0;
  logic [N_PORTS-1:0]    sleep = '0, dev_wake = '0;
  logic [N_PORTS-1:0]    port_tx_valid, port_tx_ready, port_rx_ready;
  logic [N_PORTS-1:0]    port_link_active, port_wake_req, port_lp_req;
  logic [N_PORTS-1:0]    wake_notice_port, port_suspended, port_reset;
  logic [N_PORTS-1:0]    attach_evt, detach_evt, rwake_evt;
  int                    err_count = 0, comparisons = 0, cycles = 0;

  hpr_router dut_u
  (
    .clk, .reset_n, .dn_in_valid, .dn_in_ready, .dn_in_data, .dn_in_last,
    .dn_in_route, .dn_in_tsp, .port_tx_valid, .port_tx_ready,
    .port_tx_data, .port_tx_last, .port_rx_valid, .port_rx_ready,
    .port_rx_data, .port_rx_last, .up_tx_valid, .up_tx_ready, .up_tx_data,
    .up_tx_last, .up_link_active, .up_lp_req, .up_wake_req,
    .port_link_active, .port_wake_req, .port_lp_req, .wake_notice_host,
    .wake_notice_port, .idle_timeout, .port_suspend_cmd, .port_resume_cmd,
    .port_suspended, .hub_suspend, .up_reset, .port_reset_cmd, .port_reset,
    .port_connected, .rwake_enable, .port_remote_wake, .attach_evt,
    .detach_evt, .rwake_evt
  );

  hpr_port_model partner_u
  (
    .clk, .sleep, .dev_wake, .stall, .wake_req(port_wake_req),
    .lp_req(port_lp_req), .link_active(port_link_active),
    .tx_ready(port_tx_ready)
  );

  always #50 clk = ~clk;

  task automatic wrap_up;
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] seen, exp, input string msg);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // the whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      chk(1'b0, 1'b1, "timeout");
      wrap_up;
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  function automatic logic [N_PORTS-1:0] obs(input int s);
    case (s)
      0: return attach_evt;
      1: return detach_evt;
      2: return rwake_evt;
      3: return port_reset;
      4: return port_lp_req;
      5: return N_PORTS'(up_tx_valid);
      6: return port_tx_valid;
      7: return N_PORTS'(wake_notice_host);
      default: return N_PORTS'(up_lp_req);
    endcase
  endfunction

  // stops at the first falling edge where the watched output is nonzero
  task automatic watch(input int s, n, output logic [N_PORTS-1:0] v);
    v = PORT_NONE;
    repeat (n)
    begin
      @(negedge clk);
      if (obs(s) !== PORT_NONE)
      begin
        v = obs(s);
        break;
      end
    end
  endtask

  task automatic send(input logic [ROUTE_W-1:0] r, input logic t,
                      input logic [DATA_W-1:0] d);
    @(posedge clk);
    dn_in_valid <= 1'b1;
    dn_in_route <= r;
    dn_in_tsp   <= t;
    dn_in_data  <= d;
    do @(posedge clk); while (dn_in_ready !== 1'b1);
    dn_in_valid <= 1'b0;
  endtask

  task automatic t_route;
    logic [N_PORTS-1:0] v;
    logic [DATA_W-1:0]  d;
    for (int r = 0; r < N_PORTS; r++)
    begin
      d = 32'ha5000000 | r;
      if (r == 3)
        @(posedge clk) stall <= 1'b1;
      send(ROUTE_W'(r), 1'b0, d);
      watch(6, 20, v);
      chk(v, PORT_ONE << r, "route mask");
      chk(port_tx_data, d, "route data");
      chk(port_tx_last, 1'b1, "route last");
    end
    cyc(3);
    @(negedge clk) chk(port_tx_valid, 4'h8, "word held on stall");
    @(posedge clk) stall <= 1'b0;
  endtask

  task automatic t_tsp;
    logic [N_PORTS-1:0] v;
    @(posedge clk) sleep <= 4'h3;
    @(posedge clk) sleep <= PORT_NONE;
    send(ROUTE_W'(1), 1'b1, 32'h7157a000);
    watch(6, 20, v);
    chk(v, 4'hc, "timestamp mask");
    chk(port_wake_req, PORT_NONE, "timestamp wakes nobody");
  endtask

  task automatic t_wake;
    logic [N_PORTS-1:0] v;
    send(ROUTE_W'(0), 1'b0, 32'h3a4e0000);
    watch(7, 20, v);
    chk(v, 4'h1, "host notice");
    chk(wake_notice_port, 4'h1, "port notice");
    chk(port_wake_req, 4'h1, "wake request");
    chk(port_tx_valid, PORT_NONE, "held while asleep");
    watch(6, 20, v);
    chk(v, 4'h1, "delivered after wake");
    chk(port_tx_data, 32'h3a4e0000, "wake data");
  endtask

  task automatic t_lp;
    logic [N_PORTS-1:0] v;
    chk(up_lp_req, 1'b0, "upstream stays up");
    @(posedge clk) idle_timeout <= 16'h0001;
    watch(4, 60, v);
    chk(v, 4'hd, "idle expiry on awake ports only");
    wait (port_link_active === PORT_NONE);
    watch(8, 10, v);
    chk(v, 4'h1, "upstream low power");
    @(posedge clk) idle_timeout <= TIMER_OFF;
  endtask

  task automatic t_up;
    logic [N_PORTS-1:0] v;
    for (int p = 0; p < N_PORTS; p++)
    begin
      @(posedge clk);
      up_link_active <= (p != 0);
      dev_wake[p] <= 1'b1;
      port_rx_data[p*DATA_W +: DATA_W] <= 32'h5a000000 | p;
      wait (port_link_active[p] === 1'b1);
      @(posedge clk) port_rx_valid[p] <= 1'b1;
      do @(posedge clk); while (port_rx_ready[p] !== 1'b1);
      port_rx_valid[p] <= 1'b0;
      dev_wake[p] <= 1'b0;
      if (p == 0)
      begin
        cyc(3);
        @(negedge clk) chk(up_wake_req, 1'b1, "upstream wake");
        chk(up_tx_valid, 1'b0, "nothing sent while down");
        @(posedge clk) up_link_active <= 1'b1;
      end
      watch(5, 10, v);
      chk(up_tx_data, 32'h5a000000 | p, "merged data");
      chk(up_tx_last, 1'b1, "merged last");
    end
  endtask

  task automatic t_evt;
    logic [N_PORTS-1:0] v;
    chk(port_suspended, PORT_NONE, "no self suspend");
    @(posedge clk) port_connected <= 4'h5;
    watch(0, 4, v);
    chk(v, 4'h5, "attach");
    @(negedge clk) chk(attach_evt, PORT_NONE, "attach pulse");
    @(posedge clk) port_connected <= PORT_NONE;
    watch(1, 4, v);
    chk(v, 4'h5, "detach");
    @(posedge clk) port_remote_wake <= 4'h2;
    watch(2, 4, v);
    chk(v, PORT_NONE, "wake not enabled");
    @(posedge clk) port_remote_wake <= PORT_NONE;
    rwake_enable <= 4'h2;
    up_link_active <= 1'b0;
    @(posedge clk) port_remote_wake <= 4'h2;
    watch(2, 4, v);
    chk(v, 4'h2, "remote wake");
    chk(up_wake_req, 1'b1, "wake reaches sleeping host");
    @(posedge clk) port_suspend_cmd <= 4'h8;
    up_link_active <= 1'b1;
    @(posedge clk) port_suspend_cmd <= PORT_NONE;
    @(negedge clk) chk(port_suspended, 4'h8, "suspend");
    @(posedge clk) port_resume_cmd <= 4'h8;
    @(posedge clk) port_resume_cmd <= PORT_NONE;
    @(negedge clk) chk(port_suspended, PORT_NONE, "resume");
    @(posedge clk) hub_suspend <= 1'b1;
    cyc(1);
    @(negedge clk) chk(port_suspended, 4'hf, "hub suspend");
    @(posedge clk) hub_suspend <= 1'b0;
    up_reset <= 1'b1;
    @(posedge clk) up_reset <= 1'b0;
    @(negedge clk) chk(port_reset, 4'hf, "reset propagates");
    chk(port_suspended, PORT_NONE, "reset clears suspend");
    @(posedge clk) port_reset_cmd <= 4'h4;
    @(posedge clk) port_reset_cmd <= PORT_NONE;
    @(negedge clk) chk(port_reset, 4'h4, "port reset");
    @(negedge clk) chk(port_reset, PORT_NONE, "port reset pulse");
  endtask

  initial
  begin
    cyc(4);
    reset_n <= 1'b1;
    cyc(3);
    t_route;
    t_tsp;
    t_wake;
    t_lp;
    t_up;
    t_evt;
    wrap_up;
  end
endmodule
